/* File: rtl/msc_pkg.sv */
// Constants shared by the MII strap configuration latch
`default_nettype none
package msc_pkg;
    // Strap and pin bit positions in the captured vector
    localparam int P5_BIT0 = 0;
    localparam int P5_BIT1 = 1;
    localparam int P5_BIT2 = 2;
    localparam int P5_BIT3 = 3;
    localparam int P5_ERR = 4;
    localparam int P5_CRS = 5;
    localparam int P5_COL = 6;
    localparam int SW_BIT1 = 7;
    localparam int SW_BIT2 = 8;
    localparam int SW_BIT3 = 9;
    localparam int STRAP_W = 10;
    localparam int P5_PINS = 7;
    // Two extra synchroniser lanes carry the switch clock pin levels
    localparam int SW_TXC = 10;
    localparam int SW_RXC = 11;
    localparam int SYNC_W = 12;
    localparam logic [STRAP_W-1:0] STRAP_RESET = 10'h000;

    // Register map, byte addresses
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_STRAP = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_CONFIG = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h0C;

    // Control register fields and reset value
    localparam int CTRL_P5_OE = 0;
    localparam int CTRL_SW_OE = 1;
    localparam int CTRL_CLK_DRIVE = 2;
    localparam int CTRL_W = 3;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h7;

    // Decoded configuration fields
    localparam int CFG_P5_FLOW = 0;
    localparam int CFG_P5_BACKP = 1;
    localparam int CFG_P5_DROP = 2;
    localparam int CFG_P5_AGGR = 3;
    localparam int CFG_P5_LEN = 4;
    localparam int CFG_P5_FDUP = 5;
    localparam int CFG_P5_FFLOW = 6;
    localparam int CFG_SW_FLOW = 7;
    localparam int CFG_SW_HALF = 8;
    localparam int CFG_SW_10M = 9;
    localparam int CFG_W = 10;

    // Status fields
    localparam int STAT_VALID = 0;
    localparam int STAT_TXC = 1;
    localparam int STAT_RXC = 2;

    // Packet length limits: 1518, 1522 and 1536 bytes
    localparam logic [10:0] LEN_UNTAGGED = 11'h5EE;
    localparam logic [10:0] LEN_TAGGED = 11'h5F2;
    localparam logic [10:0] LEN_HUGE = 11'h600;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Timing: core clock period and MII clock half periods in picoseconds
    localparam int CLK_PERIOD_PS = 5000;
    localparam int MII100_HALF_PS = 20000;
    localparam int MII10_HALF_PS = 200000;
    localparam logic [5:0] HALF100_CYC = 6'(MII100_HALF_PS / CLK_PERIOD_PS);
    localparam logic [5:0] HALF10_CYC = 6'(MII10_HALF_PS / CLK_PERIOD_PS);
    // Cycles the pins stay inputs after reset release before capture
    localparam logic [1:0] SAMPLE_CYC = 2'h3;

    typedef enum logic {
        ST_SAMPLE = 1'b0,
        ST_RUN = 1'b1
    } msc_state_t;
endpackage
`default_nettype wire

/* File: rtl/msc_sync.sv */
// Two-flop synchroniser for strap and clock pin levels
`default_nettype none
module msc_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // Pin levels and synchronised copy
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta;

    // Reset to low: the pins idle at their weak pull-down level
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            meta <= '0;
            q_o <= '0;
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule
`default_nettype wire

/* File: rtl/msc_latch.sv */
// Strap capture, MII pin direction control and register slave
`default_nettype none
module msc_latch (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // Port-5 dual-role pins
    input wire logic phy5_receive_bit0_i,
    input wire logic phy5_receive_bit1_i,
    input wire logic phy5_receive_bit2_i,
    input wire logic phy5_receive_bit3_i,
    input wire logic phy5_receive_error_i,
    input wire logic phy5_carrier_sense_i,
    input wire logic phy5_collision_i,
    output logic [3:0] phy5_receive_data_o,
    output logic phy5_receive_error_o,
    output logic phy5_carrier_sense_o,
    output logic phy5_collision_o,
    output logic phy5_pins_oe_o,
    // Switch MII dual-role pins
    input wire logic switch_port_receive_bit1_i,
    input wire logic switch_port_receive_bit2_i,
    input wire logic switch_port_receive_bit3_i,
    output logic [2:0] switch_port_receive_data_o,
    output logic switch_port_pins_oe_o,
    // Switch MII clock pins
    input wire logic switch_port_transmit_clock_i,
    output logic switch_port_transmit_clock_o,
    output logic switch_port_transmit_clock_oe_o,
    input wire logic switch_port_receive_clock_i,
    output logic switch_port_receive_clock_o,
    output logic switch_port_receive_clock_oe_o,
    // Weak pull-down enable for all strap pins
    output logic strap_pulldown_en_o,
    // MII output data from the MACs
    input wire logic [3:0] p5_rx_data_i,
    input wire logic p5_rx_error_i,
    input wire logic p5_carrier_i,
    input wire logic p5_collision_i,
    input wire logic [2:0] sw_rx_data_i,
    // Configuration to the MACs
    output logic cfg_valid_o,
    output logic p5_flow_ctrl_en_o,
    output logic p5_back_pressure_en_o,
    output logic p5_drop_excess_col_o,
    output logic p5_aggr_backoff_en_o,
    output logic [10:0] p5_max_len_untagged_o,
    output logic [10:0] p5_max_len_tagged_o,
    output logic p5_force_duplex_o,
    output logic p5_force_flow_o,
    output logic sw_fd_flow_ctrl_en_o,
    output logic sw_half_duplex_o,
    output logic sw_speed_10_o,
    // AXI4-Lite slave
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [msc_pkg::ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    output logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    input wire logic [msc_pkg::ADDR_W-1:0] s_axi_araddr_i,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o
);
    msc_pkg::msc_state_t state;
    logic [msc_pkg::SYNC_W-1:0] pin_raw;
    logic [msc_pkg::SYNC_W-1:0] pin_sync;
    logic [msc_pkg::STRAP_W-1:0] strap;
    logic [msc_pkg::CFG_W-1:0] cfg;
    logic [msc_pkg::CTRL_W-1:0] ctrl;
    logic [1:0] sample_cnt;
    logic [5:0] div_cnt;
    logic [5:0] half_cyc;
    logic mii_clk;
    logic run;
    logic aw_hold;
    logic w_hold;
    logic [msc_pkg::ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;

    assign pin_raw = {switch_port_receive_clock_i,
                      switch_port_transmit_clock_i,
                      switch_port_receive_bit3_i,
                      switch_port_receive_bit2_i,
                      switch_port_receive_bit1_i,
                      phy5_collision_i, phy5_carrier_sense_i,
                      phy5_receive_error_i, phy5_receive_bit3_i,
                      phy5_receive_bit2_i, phy5_receive_bit1_i,
                      phy5_receive_bit0_i};

    // Pins are asynchronous to the core clock
    msc_sync #(.W(msc_pkg::SYNC_W)) u_msc_sync (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .d_i(pin_raw),
        .q_o(pin_sync)
    );

    // Pins stay inputs until the synchroniser holds post-reset levels
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            state <= msc_pkg::ST_SAMPLE;
            sample_cnt <= 2'h0;
        end else begin
            case (state)
                msc_pkg::ST_SAMPLE: begin
                    sample_cnt <= sample_cnt + 2'h1;
                    if (sample_cnt == msc_pkg::SAMPLE_CYC - 2'h1) begin
                        state <= msc_pkg::ST_RUN;
                    end
                end
                msc_pkg::ST_RUN: begin
                    state <= msc_pkg::ST_RUN;
                end
                default: begin
                    state <= msc_pkg::ST_SAMPLE;
                end
            endcase
        end
    end

    assign run = (state == msc_pkg::ST_RUN);
    assign cfg_valid_o = run;

    // One capture only; later pin activity is MII traffic
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            strap <= msc_pkg::STRAP_RESET;
        end else if (!run && sample_cnt == msc_pkg::SAMPLE_CYC - 2'h1) begin
            strap <= pin_sync[msc_pkg::STRAP_W-1:0];
        end
    end

    // Default on every pin is the pulled-down level
    always_comb begin
        cfg = '0;
        cfg[msc_pkg::CFG_P5_FLOW] = !strap[msc_pkg::P5_BIT3];
        cfg[msc_pkg::CFG_P5_BACKP] = strap[msc_pkg::P5_BIT2];
        cfg[msc_pkg::CFG_P5_DROP] = !strap[msc_pkg::P5_BIT1];
        cfg[msc_pkg::CFG_P5_AGGR] = strap[msc_pkg::P5_BIT0];
        cfg[msc_pkg::CFG_P5_LEN] = strap[msc_pkg::P5_ERR];
        cfg[msc_pkg::CFG_P5_FDUP] = strap[msc_pkg::P5_CRS];
        cfg[msc_pkg::CFG_P5_FFLOW] = strap[msc_pkg::P5_COL];
        cfg[msc_pkg::CFG_SW_FLOW] = strap[msc_pkg::SW_BIT3];
        cfg[msc_pkg::CFG_SW_HALF] = strap[msc_pkg::SW_BIT2];
        cfg[msc_pkg::CFG_SW_10M] = strap[msc_pkg::SW_BIT1];
    end

    assign p5_flow_ctrl_en_o = cfg[msc_pkg::CFG_P5_FLOW];
    assign p5_back_pressure_en_o = cfg[msc_pkg::CFG_P5_BACKP];
    assign p5_drop_excess_col_o = cfg[msc_pkg::CFG_P5_DROP];
    assign p5_aggr_backoff_en_o = cfg[msc_pkg::CFG_P5_AGGR];
    assign p5_max_len_untagged_o = cfg[msc_pkg::CFG_P5_LEN] ?
        msc_pkg::LEN_HUGE : msc_pkg::LEN_UNTAGGED;
    assign p5_max_len_tagged_o = cfg[msc_pkg::CFG_P5_LEN] ?
        msc_pkg::LEN_HUGE : msc_pkg::LEN_TAGGED;
    assign p5_force_duplex_o = cfg[msc_pkg::CFG_P5_FDUP];
    assign p5_force_flow_o = cfg[msc_pkg::CFG_P5_FFLOW];
    assign sw_fd_flow_ctrl_en_o = cfg[msc_pkg::CFG_SW_FLOW];
    assign sw_half_duplex_o = cfg[msc_pkg::CFG_SW_HALF];
    assign sw_speed_10_o = cfg[msc_pkg::CFG_SW_10M];

    // Weak pull-downs only while the pins are straps
    assign strap_pulldown_en_o = !run;
    assign phy5_pins_oe_o = run && ctrl[msc_pkg::CTRL_P5_OE];
    assign switch_port_pins_oe_o = run && ctrl[msc_pkg::CTRL_SW_OE];

    // Registered MII outputs; carrier and collision keep MII duty
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            phy5_receive_data_o <= 4'h0;
            phy5_receive_error_o <= 1'b0;
            phy5_carrier_sense_o <= 1'b0;
            phy5_collision_o <= 1'b0;
            switch_port_receive_data_o <= 3'h0;
        end else begin
            phy5_receive_data_o <= p5_rx_data_i;
            phy5_receive_error_o <= p5_rx_error_i;
            phy5_carrier_sense_o <= p5_carrier_i;
            phy5_collision_o <= p5_collision_i;
            switch_port_receive_data_o <= sw_rx_data_i;
        end
    end

    // PHY mode: divide core clock to the strapped MII rate
    assign half_cyc = sw_speed_10_o ? msc_pkg::HALF10_CYC :
        msc_pkg::HALF100_CYC;
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            div_cnt <= 6'h00;
            mii_clk <= 1'b0;
        end else if (!run) begin
            div_cnt <= 6'h00;
            mii_clk <= 1'b0;
        end else if (div_cnt == half_cyc - 6'h01) begin
            div_cnt <= 6'h00;
            mii_clk <= !mii_clk;
        end else begin
            div_cnt <= div_cnt + 6'h01;
        end
    end

    // MAC mode releases both clock pins so the far PHY drives them
    assign switch_port_transmit_clock_o = mii_clk;
    assign switch_port_receive_clock_o = mii_clk;
    assign switch_port_transmit_clock_oe_o =
        run && ctrl[msc_pkg::CTRL_CLK_DRIVE];
    assign switch_port_receive_clock_oe_o =
        run && ctrl[msc_pkg::CTRL_CLK_DRIVE];

    // Write path: address and data taken in either order
    assign s_axi_awready_o = !aw_hold && !s_axi_bvalid_o;
    assign s_axi_wready_o = !w_hold && !s_axi_bvalid_o;
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr <= '0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= msc_pkg::RESP_OKAY;
            ctrl <= msc_pkg::CTRL_RESET;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_hold <= 1'b1;
                aw_addr <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_hold <= 1'b1;
                w_data <= s_axi_wdata_i;
                w_strb <= s_axi_wstrb_i;
            end
            if (aw_hold && w_hold) begin
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= msc_pkg::RESP_OKAY;
                case (aw_addr)
                    msc_pkg::ADDR_CTRL: begin
                        if (w_strb[0]) begin
                            ctrl <= w_data[msc_pkg::CTRL_W-1:0];
                        end
                    end
                    // Read-only registers ignore writes
                    msc_pkg::ADDR_STRAP, msc_pkg::ADDR_CONFIG,
                    msc_pkg::ADDR_STATUS: begin
                        s_axi_bresp_o <= msc_pkg::RESP_OKAY;
                    end
                    default: begin
                        s_axi_bresp_o <= msc_pkg::RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
            end
        end
    end

    // Read mux
    always_comb begin
        next_rdata = 32'h0000_0000;
        next_rresp = msc_pkg::RESP_OKAY;
        case (s_axi_araddr_i)
            msc_pkg::ADDR_STRAP: begin
                next_rdata[msc_pkg::STRAP_W-1:0] = strap;
            end
            msc_pkg::ADDR_CONFIG: begin
                next_rdata[msc_pkg::CFG_W-1:0] = cfg;
            end
            msc_pkg::ADDR_CTRL: begin
                next_rdata[msc_pkg::CTRL_W-1:0] = ctrl;
            end
            msc_pkg::ADDR_STATUS: begin
                next_rdata[msc_pkg::STAT_VALID] = run;
                next_rdata[msc_pkg::STAT_TXC] = pin_sync[msc_pkg::SW_TXC];
                next_rdata[msc_pkg::STAT_RXC] = pin_sync[msc_pkg::SW_RXC];
            end
            default: begin
                next_rresp = msc_pkg::RESP_SLVERR;
            end
        endcase
    end

    assign s_axi_arready_o = !s_axi_rvalid_o;
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= msc_pkg::RESP_OKAY;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o <= next_rdata;
            s_axi_rresp_o <= next_rresp;
        end else if (s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
        end
    end

    // Checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    sequence capture_s;
        $rose(run);
    endsequence

    sequence sample_phase_s;
        !run ##1 !run ##1 !run ##1 run;
    endsequence

    pins_input_a: assert property (
        !run |-> !phy5_pins_oe_o && !switch_port_pins_oe_o
            && strap_pulldown_en_o && !switch_port_transmit_clock_oe_o)
        else $error("strap pins driven before capture");
    pins_drive_a: assert property (
        capture_s and (ctrl[msc_pkg::CTRL_P5_OE] [*1])
            |-> phy5_pins_oe_o && !strap_pulldown_en_o)
        else $error("port-5 pins not driven after capture");
    capture_window_a: assert property (
        $fell(reset_i) |-> sample_phase_s)
        else $error("capture not three cycles after reset release");
    strap_capture_a: assert property (
        capture_s |-> strap == $past(pin_sync[msc_pkg::STRAP_W-1:0]))
        else $error("captured straps differ from pin levels");
    strap_hold_a: assert property (
        run && $past(run) |-> $stable(strap) && $stable(cfg_valid_o))
        else $error("captured straps changed after capture");
    p5_flow_a: assert property (
        capture_s |-> p5_flow_ctrl_en_o == !$past(pin_sync[3]))
        else $error("flow control strap decoded wrong");
    p5_backp_a: assert property (
        capture_s |-> p5_back_pressure_en_o == $past(pin_sync[2]))
        else $error("back pressure strap decoded wrong");
    p5_drop_a: assert property (
        capture_s |-> p5_drop_excess_col_o == !$past(pin_sync[1]))
        else $error("excess collision strap decoded wrong");
    p5_backoff_a: assert property (
        capture_s |-> p5_aggr_backoff_en_o == $past(pin_sync[0]))
        else $error("back-off strap decoded wrong");
    p5_len_a: assert property (
        run |-> (p5_max_len_tagged_o == 11'h600)
            == strap[msc_pkg::P5_ERR]
            && (p5_max_len_untagged_o == 11'h5EE)
            == !strap[msc_pkg::P5_ERR])
        else $error("packet length limit wrong");
    sw_flow_a: assert property (
        capture_s |-> sw_fd_flow_ctrl_en_o == $past(pin_sync[9]))
        else $error("switch flow control strap decoded wrong");
    sw_duplex_a: assert property (
        capture_s |-> sw_half_duplex_o == $past(pin_sync[8]))
        else $error("switch duplex strap decoded wrong");
    sw_speed_a: assert property (
        run && sw_speed_10_o && $changed(mii_clk)
            |=> !$changed(mii_clk) [*8])
        else $error("10Mbps clock toggles too fast");
    sw_clock_a: assert property (
        run && ctrl[msc_pkg::CTRL_CLK_DRIVE]
            |-> ##[1:41] $changed(switch_port_transmit_clock_o))
        else $error("switch clock pin not toggling in PHY mode");
    force_pins_a: assert property (
        capture_s |-> p5_force_duplex_o == $past(pin_sync[5])
            && p5_force_flow_o == $past(pin_sync[6]))
        else $error("force duplex or flow strap wrong");
endmodule
`default_nettype wire

/* File: test/msc_board.sv */
// Board strap resistors and the PHY side of the shared pins
`default_nettype none
module msc_board (
    // Fitted pull-ups and the device's weak pull-down
    input wire logic [9:0] strap_up_i,
    input wire logic pulldown_en_i,
    // Device drive on the shared pins
    input wire logic p5_oe_i,
    input wire logic sw_oe_i,
    input wire logic [9:0] drive_i,
    // Resolved pin levels
    output logic [9:0] pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] oe;
    assign oe = {{3{sw_oe_i}}, {7{p5_oe_i}}};
    // Fitted pull-up beats the weak pull-down
    // A floating pin shows the inverse, never a stale copy
    always_comb begin
        for (int i = 0; i < 10; i++) begin
            if (oe[i]) pin_o[i] = drive_i[i];
            else if (strap_up_i[i]) pin_o[i] = 1'b1;
            else pin_o[i] = pulldown_en_i ? 1'b0 : ~drive_i[i];
        end
    end
endmodule
`default_nettype wire

/* File: test/msc_latch_tb.sv */
// Self-checking bench for the MII strap latch
`default_nettype none
module msc_latch_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [9:0] strap = 10'h000;
    logic [9:0] mac = 10'h000;
    logic ext_clk = 1'b1;
    logic [7:0] awa = 8'h00;
    logic [7:0] ara = 8'h00;
    logic [31:0] wd = 32'h0000_0000;
    logic awv = 1'b0;
    logic wv = 1'b0;
    logic br = 1'b0;
    logic arv = 1'b0;
    logic rr = 1'b0;
    logic awr, wr, bv, arr, rv, p5_oe, sw_oe, tx_oe, rx_oe, pd_en, valid;
    logic txc_o, rxc_o;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, rd;
    logic [10:0] len_u, len_t;
    wire logic [9:0] pin, drv, cfg;
    wire logic txc, rxc;
    int n_errors = 0;
    int check_count = 0;
    int cycles = 0;
    logic [9:0] rows [4][2] = '{'{10'h000, 10'h005}, '{10'h3ff, 10'h3fa},
        '{10'h155, 10'h15f}, '{10'h2aa, 10'h2a0}};
    assign txc = tx_oe ? txc_o : ext_clk;
    assign rxc = rx_oe ? rxc_o : ext_clk;
    assign cfg[4] = (len_u == 11'h600);
    msc_board u_msc_board (.strap_up_i(strap), .pulldown_en_i(pd_en),
        .p5_oe_i(p5_oe), .sw_oe_i(sw_oe), .drive_i(drv), .pin_o(pin));
    msc_latch u_msc_latch (.mclk_i(mclk_i), .reset_i(reset_i),
        .phy5_receive_bit0_i(pin[0]), .phy5_receive_bit1_i(pin[1]),
        .phy5_receive_bit2_i(pin[2]), .phy5_receive_bit3_i(pin[3]),
        .phy5_receive_error_i(pin[4]), .phy5_carrier_sense_i(pin[5]),
        .phy5_collision_i(pin[6]), .phy5_receive_data_o(drv[3:0]),
        .phy5_receive_error_o(drv[4]), .phy5_carrier_sense_o(drv[5]),
        .phy5_collision_o(drv[6]), .phy5_pins_oe_o(p5_oe),
        .switch_port_receive_bit1_i(pin[7]),
        .switch_port_receive_bit2_i(pin[8]),
        .switch_port_receive_bit3_i(pin[9]),
        .switch_port_receive_data_o(drv[9:7]), .switch_port_pins_oe_o(sw_oe),
        .switch_port_transmit_clock_i(txc),
        .switch_port_transmit_clock_o(txc_o),
        .switch_port_transmit_clock_oe_o(tx_oe),
        .switch_port_receive_clock_i(rxc),
        .switch_port_receive_clock_o(rxc_o),
        .switch_port_receive_clock_oe_o(rx_oe), .strap_pulldown_en_o(pd_en),
        .p5_rx_data_i(mac[3:0]), .p5_rx_error_i(mac[4]),
        .p5_carrier_i(mac[5]), .p5_collision_i(mac[6]),
        .sw_rx_data_i(mac[9:7]), .cfg_valid_o(valid),
        .p5_flow_ctrl_en_o(cfg[0]), .p5_back_pressure_en_o(cfg[1]),
        .p5_drop_excess_col_o(cfg[2]), .p5_aggr_backoff_en_o(cfg[3]),
        .p5_max_len_untagged_o(len_u), .p5_max_len_tagged_o(len_t),
        .p5_force_duplex_o(cfg[5]), .p5_force_flow_o(cfg[6]),
        .sw_fd_flow_ctrl_en_o(cfg[7]), .sw_half_duplex_o(cfg[8]),
        .sw_speed_10_o(cfg[9]), .s_axi_awvalid_i(awv),
        .s_axi_awready_o(awr), .s_axi_awaddr_i(awa), .s_axi_wvalid_i(wv),
        .s_axi_wready_o(wr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf),
        .s_axi_bvalid_o(bv), .s_axi_bready_i(br), .s_axi_bresp_o(bresp),
        .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
        .s_axi_araddr_i(ara), .s_axi_rvalid_o(rv), .s_axi_rready_i(rr),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp));
    initial begin
        forever #2.5 mclk_i = ~mclk_i;
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Long enough for all rows and bus cycles, short enough to catch a hang
    always @(posedge mclk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_errors = n_errors + 1;
            $display("[FAIL] t=%0t cycles %h limit %h", $time, cycles, 3000);
            close_out();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Handshakes are judged at the falling edge, acted on at the rising one
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        @(posedge mclk_i);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        do begin
            @(negedge mclk_i);
            ta = awv && awr;
            tw = wv && wr;
            tb = bv && br;
            resp = bresp;
            @(posedge mclk_i);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
        end while (!tb);
        br <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a);
        logic ta, tr;
        @(posedge mclk_i);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        do begin
            @(negedge mclk_i);
            ta = arv && arr;
            tr = rv && rr;
            rd = rdata;
            resp = rresp;
            @(posedge mclk_i);
            if (ta) arv <= 1'b0;
        end while (!tr);
        rr <= 1'b0;
    endtask
    initial begin
        for (int i = 0; i < 4; i++) begin
            strap <= rows[i][0];
            reset_i <= 1'b1;
            repeat (16) @(posedge mclk_i);
            chk({p5_oe, sw_oe, tx_oe, rx_oe, pd_en, valid}, 6'h02);
            chk(cfg, 10'h005);
            reset_i <= 1'b0;
            repeat (2) @(posedge mclk_i);
            @(negedge mclk_i);
            chk(valid, 1'b0);
            @(negedge mclk_i);
            chk({valid, pd_en, p5_oe, sw_oe}, 4'hb);
            chk({tx_oe, rx_oe}, 2'h3);
            chk(cfg, rows[i][1]);
            chk(len_u, rows[i][0][4] ? 11'h600 : 11'h5ee);
            chk(len_t, rows[i][0][4] ? 11'h600 : 11'h5f2);
            axi_rd(msc_pkg::ADDR_STRAP);
            chk(rd, {22'h00_0000, rows[i][0]});
            axi_rd(msc_pkg::ADDR_CONFIG);
            chk(rd, {22'h00_0000, rows[i][1]});
            // First half period is 4 cycles at 100M, 40 at 10M
            @(negedge mclk_i);
            chk({txc_o, rxc_o}, {2{!rows[i][0][7]}});
            @(posedge mclk_i);
            $display("strap row %0d done", i);
        end
        mac <= 10'h1c6;
        repeat (2) @(posedge mclk_i);
        @(negedge mclk_i);
        chk(pin, 10'h1c6);
        $display("pin output test done");
        axi_wr(msc_pkg::ADDR_CTRL, 32'h0000_0000);
        chk(resp, msc_pkg::RESP_OKAY);
        strap <= 10'h155;
        repeat (4) @(posedge mclk_i);
        axi_rd(msc_pkg::ADDR_STRAP);
        chk(rd, 32'h0000_02aa);
        axi_rd(msc_pkg::ADDR_STATUS);
        chk({rd, tx_oe, rx_oe, p5_oe}, 35'h0_0000_0038);
        ext_clk <= 1'b0;
        repeat (4) @(posedge mclk_i);
        axi_rd(msc_pkg::ADDR_STATUS);
        chk(rd, 32'h0000_0001);
        axi_wr(msc_pkg::ADDR_STRAP, 32'h0000_0000);
        chk(resp, msc_pkg::RESP_OKAY);
        axi_rd(msc_pkg::ADDR_STRAP);
        chk(rd, 32'h0000_02aa);
        axi_wr(8'h10, 32'h0000_0007);
        chk(resp, msc_pkg::RESP_SLVERR);
        axi_rd(8'h10);
        chk(resp, msc_pkg::RESP_SLVERR);
        axi_wr(msc_pkg::ADDR_CTRL, 32'h0000_0007);
        axi_rd(msc_pkg::ADDR_CTRL);
        chk(rd, 32'h0000_0007);
        $display("register test done");
        close_out();
    end
endmodule
`default_nettype wire
